// ==== logic/ails_pkg.sv ====
// constants and types shared by the adc integrity, lock and status block
// assumes a register access port already decoded from the serial framing layer
`default_nettype none

package ails_pkg;

  // register indices of the access port
  localparam logic [3:0] ADDR_CURRENT   = 4'h0;
  localparam logic [3:0] ADDR_VOLT1     = 4'h1;
  localparam logic [3:0] ADDR_VOLT2     = 4'h2;
  localparam logic [3:0] ADDR_SMP_CRC   = 4'h3;
  localparam logic [3:0] ADDR_SETUP_CRC = 4'h4;
  localparam logic [3:0] ADDR_THERM_OFS = 4'h5;
  localparam logic [3:0] ADDR_SETUP     = 4'h6;
  localparam logic [3:0] ADDR_SNAPSHOT  = 4'h7;
  localparam logic [3:0] ADDR_CNT_LOW   = 4'h8;
  localparam logic [3:0] ADDR_CNT_HIGH  = 4'h9;
  localparam logic [3:0] ADDR_KEY       = 4'ha;
  localparam logic [3:0] ADDR_FLAGS_A   = 4'hb;
  localparam logic [3:0] ADDR_FLAGS_B   = 4'hc;

  // protection key values
  localparam logic [7:0] KEY_LOCK   = 8'hca;
  localparam logic [7:0] KEY_UNLOCK = 8'h9c;

  // device_setup fields and reset value
  localparam int         SETUP_RATE_LO  = 4;
  localparam int         SETUP_RATE_HI  = 5;
  localparam int         SETUP_TEMP_SEL = 3;
  localparam logic [7:0] SETUP_RESET    = 8'h00;

  // condition flag positions
  localparam int FLAG_A_RESET_ON = 0;
  localparam int FLAG_A_CRC_CHG  = 1;
  localparam int FLAG_A_PROT     = 2;
  localparam int FLAG_B_MISSED   = 3;
  localparam int FLAG_B_BIT7     = 7;

  // crc constants
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam int          CRC_SMP_STEPS  = 72;
  localparam int          CRC_SETUP_STEPS = 64;

  // output cycle divider: base ratio, scaled by 2^field
  localparam int          RATE_BASE_DIV = 512;
  localparam int          RATE_CNT_W    = 12;
  localparam int          RESET_HOLD    = 16;

  typedef struct packed {
    logic [23:0] second_voltage_result;
    logic [23:0] first_voltage_result;
    logic [23:0] current_result;
  } ails_samples_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01
  } ails_state_t;

endpackage : ails_pkg

`default_nettype wire

// ==== logic/ails_core.sv ====
// integrity, write lock and status logic of a three channel converter
// assumes samples come from the filters, and register accesses are decoded
// from the serial port, one access per cycle, synchronous to clk_in
//
// Behaviour
// - a sample crc is computed once every output cycle at the set rate
// - both crcs use polynomial x^16 + x^12 + x^5 + 1
// - sample crc takes bytes least significant first, bits msb first
// - 72 bit sequence: current, first voltage, second voltage results
// - crc starts all ones, shifts with feedback, 72 steps then stored
// - sample crc is readable at its own register address
// - setup crc each output cycle over setup, offset and two flag bits
// - setup crc uses same start and order, 64 steps
// - setup bit 3 selects temperature sensor for the third converter
// - read only signed 8 bit thermal offset, stored negated
// - write protection is off after reset
// - protected: setup writes ignored, reads always served
// - key register: 0xca locks, 0x9c unlocks
// - flags_a bit 1 set on setup crc change, cleared by read
// - flags_a bit 2 set on lock, read clears, set again next output cycle while locked
// - flags_a bit 0 high during reset, cleared when reset period ends
// - flags_b bit 3 set when results unread in a cycle, read clears
// - both flag registers readable, each at its own address
// - rate field divides clock by 512, 1024, 2048 or 4096
// - each result register is 24 bit two's complement
`default_nettype none

module ails_core #(
  parameter logic [7:0] THERMAL_OFFSET = 8'h00,
  parameter int         RESET_CYCLES   = ails_pkg::RESET_HOLD
) (
  // clock and resets
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire logic                  soft_rst_in,
  // converter samples from the filters
  input  wire ails_pkg::ails_samples_t samples_in,
  // register access port
  input  wire logic                  reg_rd_in,
  input  wire logic                  reg_wr_in,
  input  wire logic [3:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  output logic [23:0]                reg_rdata_out,
  output logic                       reg_rvalid_out,
  // controls to the analog side
  output logic                       temp_select_out,
  output logic                       narrow_band_select_out,
  output logic                       output_cycle_out,
  output logic                       reset_active_out
);

  // reverse the bit order inside every byte of a 24 bit word
  function automatic logic [23:0] byte_flip24(input logic [23:0] w);
    logic [23:0] r;
    r = '0;
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 8; m++) begin
        r[k*8+m] = w[k*8+7-m];
      end
    end
    return r;
  endfunction : byte_flip24

  // serial crc over seq[0] first, for the given number of steps
  function automatic logic [15:0] crc_run(input logic [71:0] seq, input int steps);
    logic [15:0] b;
    logic        fb;
    b  = ails_pkg::CRC_INIT;
    fb = 1'b0;
    for (int j = 0; j < ails_pkg::CRC_SMP_STEPS; j++) begin
      if (j < steps) begin
        fb = seq[j] ^ b[15];
        b  = {b[14:0], 1'b0} ^ ({16{fb}} & ails_pkg::CRC_POLY);
      end
    end
    return b;
  endfunction : crc_run

  localparam int RC_W = ails_pkg::RATE_CNT_W;

  ails_pkg::ails_state_t state_r;
  logic                  rst_any;
  logic [7:0]            hold_cnt_r;
  logic [7:0]            setup_r;
  logic [7:0]            snapshot_r;
  logic [7:0]            cnt_low_r;
  logic [7:0]            cnt_high_r;
  logic                  locked_r;
  logic [RC_W-1:0]       div_cnt_r;
  logic [RC_W-1:0]       div_last;
  logic                  tick;
  ails_pkg::ails_samples_t res_r;
  logic [15:0]           smp_crc_r;
  logic [15:0]           smp_crc_nxt;
  logic [15:0]           setup_crc_r;
  logic [15:0]           setup_crc_nxt;
  logic [71:0]           smp_seq;
  logic [71:0]           setup_seq;
  logic [7:0]            flags_a;
  logic [7:0]            flags_b;
  logic                  crc_chg_r;
  logic                  prot_r;
  logic                  missed_r;
  logic                  have_sample_r;
  logic [2:0]            seen_r;
  logic                  wr_ok;
  logic                  key_lock;
  logic                  rd_a;
  logic                  rd_b;

  assign rst_any  = srst_in | soft_rst_in;
  assign wr_ok    = reg_wr_in & ~locked_r;
  assign key_lock = reg_wr_in && reg_addr_in == ails_pkg::ADDR_KEY
                    && reg_wdata_in == ails_pkg::KEY_LOCK;
  assign rd_a     = reg_rd_in && reg_addr_in == ails_pkg::ADDR_FLAGS_A;
  assign rd_b     = reg_rd_in && reg_addr_in == ails_pkg::ADDR_FLAGS_B;

  // reset period sequencer
  // reset flag window
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      state_r    <= ails_pkg::ST_RESET;
      hold_cnt_r <= '0;
    end else if (state_r == ails_pkg::ST_RESET) begin
      if (hold_cnt_r == 8'(RESET_CYCLES - 1)) begin
        state_r <= ails_pkg::ST_RUN;
      end else begin
        hold_cnt_r <= hold_cnt_r + 8'h01;
      end
    end
  end
  assign reset_active_out = (state_r != ails_pkg::ST_RUN);

  // user configuration registers
  // unlocked after reset
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      locked_r <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == ails_pkg::ADDR_KEY) begin
      case (reg_wdata_in)
        ails_pkg::KEY_LOCK:   locked_r <= 1'b1;
        ails_pkg::KEY_UNLOCK: locked_r <= 1'b0;
        default:              locked_r <= locked_r;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      setup_r    <= ails_pkg::SETUP_RESET;
      snapshot_r <= 8'h00;
      cnt_low_r  <= 8'h00;
      cnt_high_r <= 8'h00;
    end else if (wr_ok) begin
      case (reg_addr_in)
        ails_pkg::ADDR_SETUP:    setup_r    <= reg_wdata_in;
        ails_pkg::ADDR_SNAPSHOT: snapshot_r <= reg_wdata_in;
        ails_pkg::ADDR_CNT_LOW:  cnt_low_r  <= reg_wdata_in;
        ails_pkg::ADDR_CNT_HIGH: cnt_high_r <= reg_wdata_in;
        default:                 setup_r    <= setup_r;
      endcase
    end
  end

  assign temp_select_out        = setup_r[ails_pkg::SETUP_TEMP_SEL];
  assign narrow_band_select_out = setup_r[7];

  // output cycle divider
  // divide by 512 shifted by the rate field
  assign div_last = RC_W'((ails_pkg::RATE_BASE_DIV
                    << setup_r[ails_pkg::SETUP_RATE_HI:ails_pkg::SETUP_RATE_LO]) - 1);
  assign tick     = (state_r == ails_pkg::ST_RUN) && (div_cnt_r >= div_last);

  always_ff @(posedge clk_in) begin
    if (rst_any || state_r != ails_pkg::ST_RUN || tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + RC_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      output_cycle_out <= 1'b0;
    end else begin
      output_cycle_out <= tick;
    end
  end

  // crc sequences
  // byte order and bit order of the sample sequence
  assign smp_seq = {byte_flip24(samples_in.second_voltage_result),
                    byte_flip24(samples_in.first_voltage_result),
                    byte_flip24(samples_in.current_result)};
  // setup array: setup, offset, flags_a bit 2, flags_b bit 7, zero fill
  // only the two named flag bits enter, else the crc-change flag would feed itself
  assign setup_seq = {24'h000000,
                      byte_flip24({16'h0000, flags_b[ails_pkg::FLAG_B_BIT7], 7'h00}),
                      byte_flip24({5'h00, flags_a[ails_pkg::FLAG_A_PROT], 2'h0,
                                   THERMAL_OFFSET, setup_r})};
  assign smp_crc_nxt   = crc_run(smp_seq, ails_pkg::CRC_SMP_STEPS);
  assign setup_crc_nxt = crc_run(setup_seq, ails_pkg::CRC_SETUP_STEPS);

  // results and their crc latched together
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      res_r       <= '0;
      smp_crc_r   <= ails_pkg::CRC_INIT;
      setup_crc_r <= ails_pkg::CRC_INIT;
    end else if (tick) begin
      res_r       <= samples_in;
      smp_crc_r   <= smp_crc_nxt;
      setup_crc_r <= setup_crc_nxt;
    end
  end

  // condition flags; a set always wins over a clearing read
  // setup crc change
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      crc_chg_r <= 1'b0;
    end else if (tick && setup_crc_nxt != setup_crc_r) begin
      crc_chg_r <= 1'b1;
    end else if (rd_a) begin
      crc_chg_r <= 1'b0;
    end
  end

  // protection flag, rearmed every output cycle while locked
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      prot_r <= 1'b0;
    end else if (key_lock || (tick && locked_r)) begin
      prot_r <= 1'b1;
    end else if (rd_a || !locked_r) begin
      prot_r <= 1'b0;
    end
  end

  // results not read within an output cycle
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      seen_r        <= 3'b000;
      have_sample_r <= 1'b0;
      missed_r      <= 1'b0;
    end else begin
      if (tick) begin
        seen_r        <= 3'b000;
        have_sample_r <= 1'b1;
      end else if (reg_rd_in && reg_addr_in <= ails_pkg::ADDR_VOLT2) begin
        seen_r[reg_addr_in[1:0]] <= 1'b1;
      end
      if (tick && have_sample_r && seen_r != 3'b111) begin
        missed_r <= 1'b1;
      end else if (rd_b) begin
        missed_r <= 1'b0;
      end
    end
  end

  always_comb begin
    flags_a = 8'h00;
    flags_a[ails_pkg::FLAG_A_RESET_ON] = reset_active_out;
    flags_a[ails_pkg::FLAG_A_CRC_CHG]  = crc_chg_r;
    flags_a[ails_pkg::FLAG_A_PROT]     = prot_r;
    flags_b = 8'h00;
    flags_b[ails_pkg::FLAG_B_MISSED]   = missed_r;
  end

  // read port: every register but the key readable whatever the lock state
  // read decode
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      reg_rdata_out  <= '0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          ails_pkg::ADDR_CURRENT:   reg_rdata_out <= res_r.current_result;
          ails_pkg::ADDR_VOLT1:     reg_rdata_out <= res_r.first_voltage_result;
          ails_pkg::ADDR_VOLT2:     reg_rdata_out <= res_r.second_voltage_result;
          ails_pkg::ADDR_SMP_CRC:   reg_rdata_out <= {8'h00, smp_crc_r};
          ails_pkg::ADDR_SETUP_CRC: reg_rdata_out <= {8'h00, setup_crc_r};
          ails_pkg::ADDR_THERM_OFS: reg_rdata_out <= {16'h0000, THERMAL_OFFSET};
          ails_pkg::ADDR_SETUP:     reg_rdata_out <= {16'h0000, setup_r};
          ails_pkg::ADDR_SNAPSHOT:  reg_rdata_out <= {16'h0000, snapshot_r};
          ails_pkg::ADDR_CNT_LOW:   reg_rdata_out <= {16'h0000, cnt_low_r};
          ails_pkg::ADDR_CNT_HIGH:  reg_rdata_out <= {16'h0000, cnt_high_r};
          ails_pkg::ADDR_FLAGS_A:   reg_rdata_out <= {16'h0000, flags_a};
          ails_pkg::ADDR_FLAGS_B:   reg_rdata_out <= {16'h0000, flags_b};
          default:                  reg_rdata_out <= '0;
        endcase
      end
    end
  end

endmodule : ails_core

`default_nettype wire

// ==== test/ails_core_properties.sv ====
// port assertions for the integrity, lock and status core
// assumes one register access per cycle and synchronous resets
`default_nettype none
module ails_core_properties #(
  parameter int RESET_CYCLES = 16
) (
  // clock and resets
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        soft_rst_in,
  // register port
  input wire logic        reg_rd_in,
  input wire logic        reg_wr_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [23:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  // status and controls
  input wire logic        temp_select_out,
  input wire logic        output_cycle_out,
  input wire logic        reset_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rst, lock_r, wsetup;
  logic [7:0] wd_r, rel_r;
  assign rst = srst_in | soft_rst_in;
  assign wsetup = reg_wr_in && reg_addr_in == 4'h6;
  // lock and unlock keys differ in bit 6, other key values leave it alone
  always_ff @(posedge clk_in) begin
    if (rst) begin
      lock_r <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == 4'ha && reg_wdata_in inside {8'hca, 8'h9c}) begin
      lock_r <= reg_wdata_in[6];
    end
  end
  always_ff @(posedge clk_in) begin
    wd_r <= reg_wdata_in;
  end
  // saturating count of edges since reset release
  always_ff @(posedge clk_in) begin
    if (rst) begin
      rel_r <= 8'h00;
    end else if (rel_r != 8'hff) begin
      rel_r <= rel_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst);
  reply_valid_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  reply_once_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("answer without read");
  zero_read_a: assert property (reg_rd_in && reg_addr_in inside {4'ha, [4'hd:4'hf]}
    |=> reg_rdata_out == 24'h0) else $error("key or unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  tick_gap_a: assert property (output_cycle_out |=> !output_cycle_out [*8])
    else $error("ticks too close");
  setup_write_a: assert property (wsetup && !lock_r |=> temp_select_out == wd_r[3])
    else $error("setup write lost");
  lock_hold_a: assert property (wsetup && lock_r |=> $stable(temp_select_out))
    else $error("setup write taken while locked");
  period_off_a: assert property (rel_r >= RESET_CYCLES + 2 |-> !reset_active_out)
    else $error("reset flag stuck");
  reset_outs_a: assert property (@(posedge clk_in) disable iff (1'b0) srst_in
    |=> reset_active_out && !reg_rvalid_out && !output_cycle_out && !temp_select_out)
    else $error("outputs not at reset values");
endmodule : ails_core_properties
bind ails_core ails_core_properties #(.RESET_CYCLES(RESET_CYCLES)) chk (
  .clk_in(clk_in), .srst_in(srst_in), .soft_rst_in(soft_rst_in), .reg_rd_in(reg_rd_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .temp_select_out(temp_select_out), .output_cycle_out(output_cycle_out),
  .reset_active_out(reset_active_out));
`default_nettype wire

// ==== test/ails_host.sv ====
// host model on the register port of the core
// assumes strobes are taken at the rising edge, answers one cycle later
`default_nettype none
module ails_host (
  // clock and answer
  input  wire logic        clk_in,
  input  wire logic [23:0] rdata_in,
  input  wire logic        rvalid_in,
  // access strobes
  output logic             rd_out,
  output logic             wr_out,
  output logic [3:0]       addr_out,
  output logic [7:0]       wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rd_out, wr_out, addr_out, wdata_out} = '0;
  end
  // released lines show the inverse, so a stale value never reads as valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {wr_out, addr_out, wdata_out} = {1'b1, a, d};
    @(negedge clk_in);
    {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(negedge clk_in);
    {rd_out, addr_out} = {1'b1, a};
    @(negedge clk_in);
    {rd_out, addr_out} = {1'b0, ~a};
    d = (rvalid_in === 1'b1) ? rdata_in : 'x;
  endtask : rd
endmodule : ails_host
`default_nettype wire

// ==== test/tb_adc_integrity_lock_status.sv ====
// self-checking bench of the integrity, lock and status core
// assumes the host model makes one register access per call
`default_nettype none
module tb_adc_integrity_lock_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_in, srst_in, soft_rst_in, rd, wr, rvalid, tsel, ocyc, ract, nb;
  ails_pkg::ails_samples_t smp;
  logic [3:0]              addr;
  logic [7:0]              wdata;
  logic [23:0]             rdata, d;
  int                      failures, cmp_count, n;
  ails_core #(.THERMAL_OFFSET(8'hf6), .RESET_CYCLES(4)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .soft_rst_in(soft_rst_in), .samples_in(smp),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .temp_select_out(tsel),
    .narrow_band_select_out(nb), .output_cycle_out(ocyc), .reset_active_out(ract));
  ails_host host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .rd_out(rd),
    .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(output int k);
    k = 0;
    while (ocyc !== 1'b1 && k < 9000) begin
      @(negedge clk_in);
      k++;
    end
    check(24'(k < 9000), 24'h1);
    @(negedge clk_in);
  endtask : tick
  function automatic logic [15:0] crc16(input logic [71:0] v, input int steps);
    logic [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < steps; j++) begin
      c = {c[14:0], 1'b0} ^ ((v[j / 8 * 8 + 7 - j % 8] ^ c[15]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc16
  task automatic t_reset;
    host.rd(4'hb, d);
    check(d & 24'h1, 24'h1);
    repeat (6) @(negedge clk_in);
    host.rd(4'hb, d);
    check({d[0], ract}, 24'h0);
    host.rd(4'h6, d);
    check(d, 24'h0);
    host.rd(4'h5, d);
    check(d, 24'hf6);
  endtask : t_reset
  // set up, lock, unlock to change, lock again
  task automatic t_lock;
    host.wr(4'h6, 8'h08);
    check(tsel, 24'h1);
    host.wr(4'ha, 8'hca);
    host.rd(4'hb, d);
    check(d & 24'h4, 24'h4);
    host.wr(4'h6, 8'h00);
    host.wr(4'h7, 8'h3c);
    host.rd(4'h6, d);
    check(d, 24'h08);
    host.rd(4'h7, d);
    check(d, 24'h0);
    host.rd(4'ha, d);
    check(d, 24'h0);
    host.rd(4'hb, d);
    check(d & 24'h4, 24'h0);
    tick(n);
    host.rd(4'hb, d);
    check(d & 24'h6, 24'h6);
    host.wr(4'ha, 8'h9c);
    host.wr(4'h6, 8'h00);
    check(tsel, 24'h0);
    host.wr(4'ha, 8'hca);
  endtask : t_lock
  task automatic t_rate;
    host.wr(4'ha, 8'h9c);
    for (int f = 0; f < 4; f++) begin
      host.wr(4'h6, 8'(f << 4));
      tick(n);
      tick(n);
      check(24'(n + 1), 24'(512 << f));
    end
    host.rd(4'hc, d);
    check(d & 24'h8, 24'h8);
    host.rd(4'hc, d);
    check(d & 24'h8, 24'h0);
    host.wr(4'h6, 8'h00);
  endtask : t_rate
  // results and their checksum latched together
  task automatic t_crc(input logic [71:0] v);
    smp = v;
    tick(n);
    tick(n);
    for (int a = 0; a < 3; a++) begin
      host.rd(4'(a), d);
      check(d, v[a * 24 +: 24]);
    end
    host.rd(4'h3, d);
    check(d, {8'h0, crc16(v, 72)});
    host.rd(4'h4, d);
    check(d, {8'h0, crc16({56'h0, 8'hf6, 8'h00}, 64)});
    host.rd(4'hc, d);
    tick(n);
    host.rd(4'hc, d);
    check(d & 24'h8, 24'h0);
  endtask : t_crc
  task automatic t_soft;
    host.wr(4'h6, 8'h08);
    host.wr(4'ha, 8'hca);
    soft_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({ract, tsel}, 24'h2);
    soft_rst_in = 1'b0;
    host.wr(4'h6, 8'h88);
    check({tsel, nb}, 24'h3);
    host.wr(4'h8, 8'h5a);
    host.rd(4'h8, d);
    check(d, 24'h5a);
  endtask : t_soft
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    {failures, cmp_count, srst_in, soft_rst_in, smp} = {32'd0, 32'd0, 1'b1, 1'b0, 72'h0};
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    t_reset();
    t_lock();
    t_rate();
    t_crc({24'h7fffff, 24'h800000, 24'h123456});
    t_crc({24'h000001, 24'hfedcba, 24'h00ff00});
    t_soft();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    end_sim();
  end
endmodule : tb_adc_integrity_lock_status
`default_nettype wire
